// ### logic/cpc_pkg.sv
package cpc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_PWR_CTRL = 8'h00;
   localparam logic [7:0] OFF_CURRENT = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
   localparam logic [7:0] OFF_IRQ_EN = 8'h14;
   // Power control fields
   localparam int BIT_SUPPLY_SWITCH_MODE = 0;
   localparam int BIT_REVERSE_SOURCE = 1;
   localparam int BIT_DUAL_PATH = 2;
   localparam int BIT_GATE_OVERRIDE = 3;
   localparam int BIT_MONITOR_MUX_DISABLE = 4;
   localparam int BIT_GATE_LEVEL = 5;
   // Status fields
   localparam int BIT_OV_LIVE = 0;
   localparam int BIT_VBUS_LIVE = 1;
   localparam int BIT_FACTORY = 2;
   localparam int BIT_REG_ON = 3;
   // Interrupt fields
   localparam int BIT_IRQ_OV = 0;
   localparam int BIT_IRQ_ATTACH = 1;
   localparam int IRQ_W = 2;
   // Reset values
   localparam logic [5:0] RST_PWR_CTRL = 6'h00;
   localparam logic [3:0] RST_CURRENT = 4'h0;
   localparam logic [IRQ_W-1:0] RST_IRQ_EN = 2'h0;
   // Activation current codes (~100, ~300, ~600 mA)
   localparam logic [3:0] CUR_100MA = 4'h2;
   localparam logic [3:0] CUR_300MA = 4'h4;
   localparam logic [3:0] CUR_600MA = 4'h7;
   localparam logic [3:0] CUR_OFF = 4'h0;

   typedef enum logic [1:0] {
      MUX_ID = 2'b00,
      MUX_CHARGE = 2'b01,
      MUX_DISCHARGE = 2'b10
   } cpc_mux_sel_t;

   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_NORMAL = 2'b01,
      MODE_FACTORY = 2'b10,
      MODE_OVERVOLT = 2'b11
   } cpc_mode_t;

   // Comparator inputs that travel together
   typedef struct packed {
      logic vbus_present;
      logic overvoltage;
      logic above_poweron;
      logic above_2v7;
      logic above_3v7;
   } cpc_comp_t;

   // Attach levels
   typedef struct packed {
      logic id_high;
      logic host_reset_n;
      logic dp;
      logic dm;
   } cpc_attach_t;
endpackage : cpc_pkg

// ### logic/cpc_charge_ctrl.sv
`timescale 1ns/1ps
module cpc_charge_ctrl (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Analog comparators and attach levels
   input wire cpc_pkg::cpc_comp_t comp_in,
   input wire cpc_pkg::cpc_attach_t attach_in,
   // Regulator and gate controls
   output logic charge_reg_enable_out,
   output logic [3:0] charge_current_field_out,
   output logic supply_reg_enable_out,
   output logic supply_path_gate_out,
   output logic charge_path_gate_out,
   output logic bus_path_open_out,
   output logic poweron_request_out,
   // Current monitor mux
   output cpc_pkg::cpc_mux_sel_t monitor_sel_out,
   output logic current_monitor_out_oe_out,
   // Interrupt
   output logic overvoltage_irq_out
);

   // Two-stage synchroniser on comparator levels
   cpc_pkg::cpc_comp_t comp_meta_ff;
   cpc_pkg::cpc_comp_t comp_ff;
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         comp_meta_ff <= '0;
         comp_ff <= '0;
      end else begin
         comp_meta_ff <= comp_in;
         comp_ff <= comp_meta_ff;
      end
   end

   // Software registers
   logic [5:0] pwr_ctrl_ff;
   logic [3:0] current_ff;
   logic [cpc_pkg::IRQ_W-1:0] irq_stat_ff;
   logic [cpc_pkg::IRQ_W-1:0] irq_en_ff;
   cpc_pkg::cpc_mode_t mode_ff;

   // APB decode
   wire access = psel_in && penable_in;
   wire wr = access && pwrite_in;
   wire hit_pwr = paddr_in == cpc_pkg::OFF_PWR_CTRL;
   wire hit_cur = paddr_in == cpc_pkg::OFF_CURRENT;
   wire hit_stat = paddr_in == cpc_pkg::OFF_STATUS;
   wire hit_istat = paddr_in == cpc_pkg::OFF_IRQ_STAT;
   wire hit_iclr = paddr_in == cpc_pkg::OFF_IRQ_CLR;
   wire hit_ien = paddr_in == cpc_pkg::OFF_IRQ_EN;
   wire mapped = hit_pwr | hit_cur | hit_stat | hit_istat | hit_iclr | hit_ien;

   wire supply_switch_mode = pwr_ctrl_ff[cpc_pkg::BIT_SUPPLY_SWITCH_MODE];
   wire reverse_source_enable = pwr_ctrl_ff[cpc_pkg::BIT_REVERSE_SOURCE];
   wire dual_path = pwr_ctrl_ff[cpc_pkg::BIT_DUAL_PATH];
   wire gate_manual_override = pwr_ctrl_ff[cpc_pkg::BIT_GATE_OVERRIDE];
   wire monitor_mux_disable = pwr_ctrl_ff[cpc_pkg::BIT_MONITOR_MUX_DISABLE];
   wire gate_manual_level = pwr_ctrl_ff[cpc_pkg::BIT_GATE_LEVEL];

   // Mode decision; over-voltage has top priority
   cpc_pkg::cpc_mode_t nxt_mode;
   assign nxt_mode = comp_ff.overvoltage ? cpc_pkg::MODE_OVERVOLT :
                     !comp_ff.vbus_present ? cpc_pkg::MODE_OFF :
                     attach_in.id_high ? cpc_pkg::MODE_FACTORY :
                     cpc_pkg::MODE_NORMAL;

   function automatic logic [3:0] step_current(input logic factory,
                                               input logic above_2v7,
                                               input logic above_3v7);
      logic [3:0] cur;
      cur = above_2v7 ? cpc_pkg::CUR_300MA : cpc_pkg::CUR_100MA;
      if (factory && above_3v7) begin
         cur = cpc_pkg::CUR_600MA;
      end
      return cur;
   endfunction : step_current

   // Activation current while host held in reset (single path)
   wire activation = mode_ff == cpc_pkg::MODE_NORMAL && !attach_in.host_reset_n;
   wire mode_change = nxt_mode != mode_ff;
   wire [3:0] auto_current =
      (nxt_mode == cpc_pkg::MODE_FACTORY) ?
         step_current(1'b1, comp_ff.above_2v7, comp_ff.above_3v7) :
      (nxt_mode == cpc_pkg::MODE_NORMAL && !attach_in.host_reset_n && !dual_path) ?
         step_current(1'b0, comp_ff.above_2v7, comp_ff.above_3v7) :
         current_ff;

   // Current field: over-voltage clear, then software write, then logic choice
   logic [3:0] nxt_current;
   assign nxt_current = (nxt_mode == cpc_pkg::MODE_OVERVOLT) ? cpc_pkg::CUR_OFF :
                        (wr && hit_cur) ? pwdata_in[3:0] :
                        mode_change ? auto_current : current_ff;

   wire ov_event = comp_ff.overvoltage && mode_ff != cpc_pkg::MODE_OVERVOLT;
   wire attach_event = nxt_mode == cpc_pkg::MODE_NORMAL && mode_ff == cpc_pkg::MODE_OFF;
   wire [cpc_pkg::IRQ_W-1:0] irq_set = {attach_event, ov_event};
   wire [cpc_pkg::IRQ_W-1:0] irq_clr = (wr && hit_iclr) ?
                                       pwdata_in[cpc_pkg::IRQ_W-1:0] : '0;
   logic [cpc_pkg::IRQ_W-1:0] nxt_irq_stat;
   assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;

   // Software registers, written only at the access edge
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pwr_ctrl_ff <= cpc_pkg::RST_PWR_CTRL;
      end else if (wr && hit_pwr) begin
         pwr_ctrl_ff <= pwdata_in[5:0];
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_en_ff <= cpc_pkg::RST_IRQ_EN;
      end else if (wr && hit_ien) begin
         irq_en_ff <= pwdata_in[cpc_pkg::IRQ_W-1:0];
      end
   end

   // Shared by hardware and software; priority lives in nxt_current
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         current_ff <= cpc_pkg::RST_CURRENT;
      end else begin
         current_ff <= nxt_current;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_stat_ff <= '0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mode_ff <= cpc_pkg::MODE_OFF;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // Output decisions from registered mode
   logic nxt_reg_en;
   logic nxt_supply_on;
   logic nxt_poweron;
   logic nxt_chg_gate;
   cpc_pkg::cpc_mux_sel_t nxt_sel;
   always_comb begin
      nxt_reg_en = 1'b0;
      nxt_supply_on = 1'b0;
      nxt_poweron = 1'b0;
      nxt_chg_gate = gate_manual_override ? gate_manual_level : 1'b0;
      case (mode_ff)
         cpc_pkg::MODE_OFF: begin
            nxt_chg_gate = 1'b1;
         end
         cpc_pkg::MODE_NORMAL: begin
            nxt_reg_en = current_ff != cpc_pkg::CUR_OFF;
            nxt_supply_on = 1'b1;
            nxt_poweron = activation ? comp_ff.above_poweron : 1'b1;
         end
         cpc_pkg::MODE_FACTORY: begin
            nxt_reg_en = current_ff != cpc_pkg::CUR_OFF;
            nxt_supply_on = 1'b1;
            nxt_poweron = comp_ff.above_poweron;
         end
         cpc_pkg::MODE_OVERVOLT: begin
            nxt_chg_gate = 1'b1;
         end
         default: begin
            nxt_chg_gate = 1'b1;
         end
      endcase
      if (reverse_source_enable && mode_ff != cpc_pkg::MODE_OVERVOLT) begin
         nxt_reg_en = 1'b0;
         nxt_chg_gate = 1'b0;
      end
      if (nxt_reg_en) begin
         nxt_sel = cpc_pkg::MUX_CHARGE;
      end else if (reverse_source_enable) begin
         nxt_sel = cpc_pkg::MUX_DISCHARGE;
      end else begin
         nxt_sel = cpc_pkg::MUX_ID;
      end
   end

   // Supply path: after over-voltage it returns in dual path mode or after a software write of the current field
   logic ov_recent_ff;
   wire ov = mode_ff == cpc_pkg::MODE_OVERVOLT;
   wire supply_on = nxt_supply_on && !ov && (dual_path || !ov_recent_ff);

   // Registered outputs; reset leaves every external path open
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         charge_reg_enable_out <= 1'b0;
      end else begin
         charge_reg_enable_out <= nxt_reg_en && !ov;
      end
   end

   // Mirror lags the field by one clock
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         charge_current_field_out <= cpc_pkg::RST_CURRENT;
      end else begin
         charge_current_field_out <= current_ff;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         supply_reg_enable_out <= 1'b0;
      end else begin
         supply_reg_enable_out <= !supply_switch_mode && supply_on;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         supply_path_gate_out <= 1'b1;
      end else begin
         supply_path_gate_out <= ov ? 1'b1 :
                                 !(supply_switch_mode && supply_on);
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         charge_path_gate_out <= 1'b1;
      end else begin
         charge_path_gate_out <= nxt_chg_gate;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bus_path_open_out <= 1'b1;
      end else begin
         bus_path_open_out <= ov || mode_ff == cpc_pkg::MODE_OFF;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         poweron_request_out <= 1'b0;
      end else begin
         poweron_request_out <= nxt_poweron;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         monitor_sel_out <= cpc_pkg::MUX_ID;
      end else begin
         monitor_sel_out <= nxt_sel;
      end
   end

   // Pin undriven during reset to save idle current; driven from the first clock after unless the mux is disabled
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         current_monitor_out_oe_out <= 1'b0;
      end else begin
         current_monitor_out_oe_out <= !monitor_mux_disable;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         overvoltage_irq_out <= 1'b0;
      end else begin
         overvoltage_irq_out <= |(nxt_irq_stat & irq_en_ff);
      end
   end

   // Cleared only by a software rewrite of the current field
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ov_recent_ff <= 1'b0;
      end else if (ov) begin
         ov_recent_ff <= 1'b1;
      end else if (wr && hit_cur) begin
         ov_recent_ff <= 1'b0;
      end
   end

   // APB read path
   logic [31:0] nxt_rdata;
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (hit_pwr) begin
         nxt_rdata[5:0] = pwr_ctrl_ff;
      end else if (hit_cur) begin
         nxt_rdata[3:0] = current_ff;
      end else if (hit_stat) begin
         nxt_rdata[cpc_pkg::BIT_OV_LIVE] = comp_ff.overvoltage;
         nxt_rdata[cpc_pkg::BIT_VBUS_LIVE] = comp_ff.vbus_present;
         nxt_rdata[cpc_pkg::BIT_FACTORY] = mode_ff == cpc_pkg::MODE_FACTORY;
         nxt_rdata[cpc_pkg::BIT_REG_ON] = charge_reg_enable_out;
      end else if (hit_istat) begin
         nxt_rdata[cpc_pkg::IRQ_W-1:0] = irq_stat_ff;
      end else if (hit_ien) begin
         nxt_rdata[cpc_pkg::IRQ_W-1:0] = irq_en_ff;
      end
   end

   // Zero-wait slave; answer registered in setup cycle
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pready_out <= 1'b0;
      end else begin
         pready_out <= psel_in && !penable_in;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pslverr_out <= 1'b0;
      end else begin
         pslverr_out <= psel_in && !penable_in && !mapped;
      end
   end

   // Read data held between reads; only valid with pready
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (psel_in && !penable_in && !pwrite_in) begin
         prdata_out <= nxt_rdata;
      end
   end
endmodule : cpc_charge_ctrl

// ### dv/cpc_monitor.sv
`timescale 1ns/1ps
module cpc_monitor (
   // Clock, reset and bus
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic pready_out,
   // Far side levels
   input wire cpc_pkg::cpc_comp_t comp_in,
   input wire cpc_pkg::cpc_attach_t attach_in,
   // Controls
   input wire logic charge_reg_enable_out,
   input wire logic [3:0] charge_current_field_out,
   input wire logic supply_reg_enable_out,
   input wire logic supply_path_gate_out,
   input wire logic charge_path_gate_out,
   input wire logic bus_path_open_out,
   input wire logic poweron_request_out,
   input wire cpc_pkg::cpc_mux_sel_t monitor_sel_out,
   input wire logic overvoltage_irq_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   // Long runs absorb the two-flop synchroniser plus decision latency
   wire ov = comp_in.overvoltage;
   wire vb = comp_in.vbus_present & ~ov;
   wire fl = vb & attach_in.id_high & ~comp_in.above_poweron;
   wire fh = vb & attach_in.id_high & comp_in.above_poweron;
   wire nm = vb & ~attach_in.id_high & attach_in.host_reset_n;
   wire nv = ~comp_in.vbus_present;
   a_ov_gates: assert property (ov [*6] |-> charge_path_gate_out && supply_path_gate_out)
      else $error("gates not opened in surge");
   a_ov_bus: assert property (ov [*6] |-> bus_path_open_out)
      else $error("bus path not opened in surge");
   a_ov_clear: assert property (ov [*7] |-> !charge_current_field_out && !supply_reg_enable_out)
      else $error("current or supply not cleared in surge");
   a_no_vbus: assert property (nv [*6] |-> !charge_reg_enable_out && !poweron_request_out)
      else $error("active without bus power");
   a_fact_low: assert property (fl [*6] |-> !poweron_request_out)
      else $error("power on below threshold");
   a_fact_high: assert property (fh [*6] |-> poweron_request_out)
      else $error("no power on above threshold");
   a_normal_on: assert property (nm [*6] |-> poweron_request_out)
      else $error("no power on with host running");
   a_mux_charge: assert property (charge_reg_enable_out [*3] |->
      monitor_sel_out == cpc_pkg::MUX_CHARGE)
      else $error("monitor not on charge sense");
   a_apb_ready: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no ready after setup");
   a_irq_hold: assert property ($fell(overvoltage_irq_out) |->
      $past(pwrite_in) || $past(pwrite_in, 2))
      else $error("interrupt dropped without a write");
   c_surge: cover property (ov [*6]);
   c_fact_high: cover property (fh [*6]);
   c_fact_low: cover property (fl [*6]);
endmodule : cpc_monitor

// ### dv/cpc_source_model.sv
`timescale 1ns/1ps
module cpc_source_model (
   // Scenario knobs
   input wire logic vbus_in,
   input wire logic surge_in,
   input wire logic [1:0] batt_lvl_in,
   input wire logic id_high_in,
   input wire logic host_run_in,
   // Toward the block
   output cpc_pkg::cpc_comp_t comp_out,
   output cpc_pkg::cpc_attach_t attach_out
);
   // Level 0 below 2.7 V, 1 up to 3.7 V, 2 above and past power-on threshold
   assign comp_out = '{vbus_in, vbus_in & surge_in, batt_lvl_in == 2'h2, batt_lvl_in != 2'h0,
                       batt_lvl_in == 2'h2};
   assign attach_out = '{id_high_in, host_run_in, vbus_in, 1'b0};
endmodule : cpc_source_model

// ### dv/charge_path_control_logic_tb_top.sv
`timescale 1ns/1ps
module charge_path_control_logic_tb_top;
   logic clk_sys_in = 1'b0;
   logic rstn_in = 1'b0;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out, rd;
   logic pready_out, pslverr_out, err;
   logic vbus = 1'b0, surge = 1'b0, id_high = 1'b0, host_run = 1'b0;
   logic [1:0] lvl = 2'h0;
   cpc_pkg::cpc_comp_t comp_in;
   cpc_pkg::cpc_attach_t attach_in;
   logic charge_reg_enable_out, supply_reg_enable_out, supply_path_gate_out, charge_path_gate_out;
   logic bus_path_open_out, poweron_request_out, current_monitor_out_oe_out, overvoltage_irq_out;
   logic [3:0] charge_current_field_out;
   cpc_pkg::cpc_mux_sel_t monitor_sel_out;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   cpc_charge_ctrl uut (.clk_sys_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .comp_in, .attach_in,
      .charge_reg_enable_out, .charge_current_field_out, .supply_reg_enable_out,
      .supply_path_gate_out, .charge_path_gate_out, .bus_path_open_out, .poweron_request_out,
      .monitor_sel_out, .current_monitor_out_oe_out, .overvoltage_irq_out);
   cpc_source_model far (.vbus_in(vbus), .surge_in(surge), .batt_lvl_in(lvl),
      .id_high_in(id_high), .host_run_in(host_run), .comp_out(comp_in), .attach_out(attach_in));
   initial begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic conclude;
      if (mismatches == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Idle edge first so a release never meets the next setup in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      do @(posedge clk_sys_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb
   task automatic wt;
      repeat (8) @(posedge clk_sys_in);
   endtask : wt
   task automatic t_regs;
      apb(1'b0, cpc_pkg::OFF_PWR_CTRL, 32'h0);
      chk(rd, 32'({cpc_pkg::RST_PWR_CTRL}));
      apb(1'b0, cpc_pkg::OFF_CURRENT, 32'h0);
      chk(rd, 32'({cpc_pkg::RST_CURRENT}));
      apb(1'b0, 8'h20, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      wt();
      chk(32'({charge_reg_enable_out, poweron_request_out}), 32'h0);
   endtask : t_regs
   task automatic t_normal;
      vbus <= 1'b1;
      host_run <= 1'b1;
      apb(1'b1, cpc_pkg::OFF_CURRENT, 32'h9);
      wt();
      chk(32'({poweron_request_out, charge_reg_enable_out, charge_current_field_out}),
         32'h39);
      chk(32'({monitor_sel_out, current_monitor_out_oe_out}), 32'h3);
      chk(32'({supply_reg_enable_out, supply_path_gate_out, charge_path_gate_out}), 32'h6);
      apb(1'b1, cpc_pkg::OFF_PWR_CTRL, 32'h10);
      wt();
      chk(32'(current_monitor_out_oe_out), 32'h0);
      // Switch mode with the charge gate forced open by hand
      apb(1'b1, cpc_pkg::OFF_PWR_CTRL, 32'h29);
      wt();
      chk(32'({supply_reg_enable_out, supply_path_gate_out, charge_path_gate_out}), 32'h1);
      apb(1'b1, cpc_pkg::OFF_PWR_CTRL, 32'h0);
   endtask : t_normal
   task automatic t_steps;
      logic [2:0] cs [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
      logic [3:0] exp;
      host_run <= 1'b0;
      foreach (cs[i]) begin
         vbus <= 1'b0;
         wt();
         {id_high, lvl} <= cs[i];
         vbus <= 1'b1;
         wt();
         exp = lvl == 2'h0 ? cpc_pkg::CUR_100MA :
               lvl == 2'h1 ? cpc_pkg::CUR_300MA : cpc_pkg::CUR_600MA;
         chk(32'({poweron_request_out, charge_current_field_out}),
            32'({lvl == 2'h2, exp}));
      end
      apb(1'b0, cpc_pkg::OFF_STATUS, 32'h0);
      chk(rd, 32'he);
      apb(1'b1, cpc_pkg::OFF_CURRENT, 32'h5);
      wt();
      chk(32'(charge_current_field_out), 32'h5);
   endtask : t_steps
   task automatic t_ov;
      id_high <= 1'b0;
      host_run <= 1'b1;
      apb(1'b1, cpc_pkg::OFF_IRQ_EN, 32'h1);
      apb(1'b1, cpc_pkg::OFF_PWR_CTRL, 32'h4);
      apb(1'b1, cpc_pkg::OFF_IRQ_CLR, 32'h3);
      surge <= 1'b1;
      wt();
      chk(32'({charge_path_gate_out, supply_path_gate_out, bus_path_open_out, overvoltage_irq_out,
         supply_reg_enable_out, charge_current_field_out}), 32'h1e0);
      apb(1'b0, cpc_pkg::OFF_STATUS, 32'h0);
      chk(32'(rd[cpc_pkg::BIT_OV_LIVE]), 32'h1);
      surge <= 1'b0;
      wt();
      apb(1'b0, cpc_pkg::OFF_STATUS, 32'h0);
      chk(32'(rd[cpc_pkg::BIT_OV_LIVE]), 32'h0);
      chk(32'({supply_reg_enable_out, charge_current_field_out}), 32'h10);
      apb(1'b1, cpc_pkg::OFF_CURRENT, 32'h6);
      wt();
      chk(32'(charge_current_field_out), 32'h6);
      apb(1'b1, cpc_pkg::OFF_IRQ_CLR, 32'h3);
      apb(1'b0, cpc_pkg::OFF_IRQ_STAT, 32'h0);
      chk({rd[30:0], overvoltage_irq_out}, 32'h0);
   endtask : t_ov
   task automatic t_mux;
      vbus <= 1'b0;
      apb(1'b1, cpc_pkg::OFF_PWR_CTRL, 32'h2);
      wt();
      chk(32'(monitor_sel_out), 32'(cpc_pkg::MUX_DISCHARGE));
      apb(1'b1, cpc_pkg::OFF_PWR_CTRL, 32'h0);
      wt();
      chk(32'(monitor_sel_out), 32'(cpc_pkg::MUX_ID));
   endtask : t_mux
   initial begin
      repeat (3) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      t_regs();
      t_normal();
      t_steps();
      t_ov();
      t_mux();
      conclude();
   end
endmodule : charge_path_control_logic_tb_top
bind cpc_charge_ctrl cpc_monitor mon (.clk_sys_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
   .pready_out, .comp_in, .attach_in, .charge_reg_enable_out, .charge_current_field_out,
   .supply_reg_enable_out, .supply_path_gate_out, .charge_path_gate_out, .bus_path_open_out,
   .poweron_request_out, .monitor_sel_out, .overvoltage_irq_out);
